/* File: core/ipt_pkg.sv */
// Package for the interrupt priority and test register block.
// Assumes one 40 MHz clock and an AHB-Lite register port of 32 bits.
package ipt_pkg;

   // ------------------------------------------------------------
   // Sizes
   // ------------------------------------------------------------
   localparam int NUM_SRC = 119;
   localparam int VEC_W = 8;
   localparam int SRC_LVL_W = 3;
   localparam int CPU_LVL_W = 4;
   localparam int REG_W = 16;
   localparam int IDX_W = 2;

   // ------------------------------------------------------------
   // Register byte offsets
   // ------------------------------------------------------------
   localparam logic [31:0] OFS_DBG_PRIO = 32'h0000_0000;
   localparam logic [31:0] OFS_TEST = 32'h0000_0004;
   localparam logic [31:0] OFS_IRQ_STAT = 32'h0000_0008;
   localparam logic [31:0] OFS_IRQ_MASK = 32'h0000_000C;
   localparam logic [31:0] MAP_SIZE = 32'h0000_0010;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int DBG_LVL_LSB = 4;
   localparam int TST_REQ_BIT = 15;
   localparam int TST_CAPSEL_BIT = 13;
   localparam int TST_LVL_LSB = 8;
   localparam int TST_VEC_LSB = 0;
   localparam int EV_RAISE_BIT = 0;
   localparam int EV_ACK_BIT = 1;
   localparam int EV_W = 2;

   // ------------------------------------------------------------
   // Reset values and fixed source mapping
   // ------------------------------------------------------------
   localparam logic [SRC_LVL_W-1:0] SRC_LVL_RST = 3'h4;
   localparam logic [SRC_LVL_W-1:0] SRC_LVL_OFF = 3'h0;
   localparam logic [CPU_LVL_W-1:0] CPU_LVL_RST = 4'h0;
   localparam logic [VEC_W-1:0] VEC_RST = 8'h00;
   localparam logic [VEC_W-1:0] DBG_VEC = 8'h5F;
   localparam logic [EV_W-1:0] EV_RST = 2'h0;

   // ------------------------------------------------------------
   // AHB codes
   // ------------------------------------------------------------
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic HRESP_OKAY = 1'b0;

   // ------------------------------------------------------------
   // Carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic en;
      logic [31:0] addr;
      logic [31:0] data;
   } ipt_wr_t;

   typedef struct packed {
      logic valid;
      logic [SRC_LVL_W-1:0] lvl;
      logic [VEC_W-1:0] vec;
   } ipt_win_t;

   typedef enum logic [1:0] {
      BUS_IDLE = 2'b00,
      BUS_WR = 2'b01,
      BUS_RD_WAIT = 2'b10
   } ipt_bus_st_t;

   // Word index of a byte address inside the map.
   function automatic logic [IDX_W-1:0] reg_index(input logic [31:0] a);
      reg_index = a[IDX_W+1:2];
   endfunction

   function automatic logic in_map(input logic [31:0] a);
      in_map = (a < MAP_SIZE);
   endfunction

endpackage

/* File: core/ipt_arbiter.sv */
// Picks the highest-level pending source; lower vector wins a tie.
// Assumes pending flags and levels come from logic on the same clock.
`timescale 1ns/10ps
`default_nettype none
module ipt_arbiter
   import ipt_pkg::*;
(
   input wire logic [NUM_SRC-1:0] src_pend,
   input wire logic [NUM_SRC*SRC_LVL_W-1:0] src_lvl,
   input wire logic [SRC_LVL_W-1:0] dbg_lvl,
   output ipt_win_t win
);

   // ------------------------------------------------------------
   // Search
   // ------------------------------------------------------------
   always_comb
   begin
      logic [SRC_LVL_W-1:0] lvl;
      lvl = SRC_LVL_OFF;
      win = '0;
      for (int i = 0; i < NUM_SRC; i++)
      begin
         lvl = (i == int'(DBG_VEC)) ? dbg_lvl : src_lvl[i*SRC_LVL_W +: SRC_LVL_W];
         if (src_pend[i] && (lvl != SRC_LVL_OFF) && (!win.valid || lvl > win.lvl))
         begin
            win.valid = 1'b1;
            win.lvl = lvl;
            win.vec = VEC_W'(i);
         end
      end
   end

endmodule
`default_nettype wire

/* File: core/ipt_ahb.sv */
// AHB-Lite slave front end: writes with no wait, reads with one wait.
// Assumes the register contents are offered combinationally by the parent.
`timescale 1ns/10ps
`default_nettype none
module ipt_ahb
   import ipt_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output ipt_wr_t wr,
   output logic [31:0] rd_addr,
   input wire logic [31:0] rd_data
);

   ipt_bus_st_t st_q;
   logic [31:0] addr_q;
   logic take;

   assign take = hsel && hready && (htrans == HTRANS_NONSEQ);

   // ------------------------------------------------------------
   // Phase tracking
   // ------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         st_q <= BUS_IDLE;
         addr_q <= 32'h0000_0000;
      end
      else if (st_q == BUS_RD_WAIT)
         st_q <= BUS_IDLE;
      else if (take)
      begin
         st_q <= hwrite ? BUS_WR : BUS_RD_WAIT;
         addr_q <= haddr;
      end
      else
         st_q <= BUS_IDLE;
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         hrdata <= 32'h0000_0000;
      else if (st_q == BUS_RD_WAIT)
         hrdata <= rd_data;
   end

   assign hreadyout = (st_q != BUS_RD_WAIT);
   assign rd_addr = addr_q;
   assign wr.en = (st_q == BUS_WR);
   assign wr.addr = addr_q;
   assign wr.data = hwdata;

endmodule
`default_nettype wire

/* File: core/ipt_top.sv */
// Interrupt request, debug-port priority and controller test registers.
// Assumes a CPU on the same clock that raises cpu_ack for one cycle to
// take the presented request, and pending flags from logic on hclk.
//
// Contract
// - Debug-port level 7 highest, 1 lowest, 0 disables the source.
// - Unused priority register bits read zero and ignore writes.
// - Bit 15 of test register reads one while a request is unacknowledged.
// - Capture select one: vector field shows the live highest pending vector.
// - Capture select zero: vector field holds the last acknowledged vector; a test register write also loads it.
// - Only a source above the current CPU level is requested.
// - New CPU level field bits 11 to 8 is plain binary 0 to 15.
// - Vector field reports values 0 to 118; live view shows lowest vector on a tie. A test register write can load any value 0 to 255 into the held view.
// - Held view reports the vector the CPU is servicing; a test register write also loads it.
// - Reset sets the debug-port priority level to 4.
`timescale 1ns/10ps
`default_nettype none
module ipt_top
   import ipt_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic [NUM_SRC-1:0] src_pend,
   input wire logic [NUM_SRC*SRC_LVL_W-1:0] src_lvl,
   input wire logic [CPU_LVL_W-1:0] cpu_level,
   input wire logic cpu_ack,
   output logic cpu_req,
   output logic [VEC_W-1:0] cpu_vec,
   output logic [CPU_LVL_W-1:0] cpu_new_level,
   output logic irq
);

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   ipt_wr_t wr;
   ipt_win_t win;
   logic [31:0] rd_addr;
   logic [31:0] rd_data;
   logic [SRC_LVL_W-1:0] dbg_lvl_q;
   logic capsel_q;
   logic [CPU_LVL_W-1:0] new_lvl_q;
   logic [VEC_W-1:0] held_vec_q;
   logic req_q;
   logic [VEC_W-1:0] req_vec_q;
   logic [SRC_LVL_W-1:0] req_lvl_q;
   logic [EV_W-1:0] stat_q;
   logic [EV_W-1:0] mask_q;
   logic [EV_W-1:0] ev;
   logic outranks;
   logic ack;
   logic raise;
   logic wr_prio;
   logic wr_test;
   logic wr_stat;
   logic wr_mask;

   // ------------------------------------------------------------
   // Bus front end
   // ------------------------------------------------------------
   ipt_ahb u_ahb
   (
      .hclk(hclk),
      .hresetn(hresetn),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hready(hready),
      .hwdata(hwdata),
      .hreadyout(hreadyout),
      .hrdata(hrdata),
      .wr(wr),
      .rd_addr(rd_addr),
      .rd_data(rd_data)
   );

   assign hresp = HRESP_OKAY;

   // Returns true when a write hits the given register offset.
   function automatic logic hit(input ipt_wr_t w, input logic [31:0] ofs);
      hit = w.en && in_map(w.addr) && (reg_index(w.addr) == reg_index(ofs));
   endfunction

   assign wr_prio = hit(wr, OFS_DBG_PRIO);
   assign wr_test = hit(wr, OFS_TEST);
   assign wr_stat = hit(wr, OFS_IRQ_STAT);
   assign wr_mask = hit(wr, OFS_IRQ_MASK);

   // ------------------------------------------------------------
   // Source selection
   // ------------------------------------------------------------
   ipt_arbiter u_arb
   (
      .src_pend(src_pend),
      .src_lvl(src_lvl),
      .dbg_lvl(dbg_lvl_q),
      .win(win)
   );

   assign outranks = win.valid && ({1'b0, win.lvl} > cpu_level);
   assign ack = req_q && cpu_ack;
   assign raise = !req_q && outranks;

   // ------------------------------------------------------------
   // Debug-port priority register
   // ------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         dbg_lvl_q <= SRC_LVL_RST;
      else if (wr_prio)
         dbg_lvl_q <= wr.data[DBG_LVL_LSB +: SRC_LVL_W];
   end

   // ------------------------------------------------------------
   // Request toward the CPU
   // ------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         req_q <= 1'b0;
      else if (ack)
         req_q <= 1'b0;
      else if (raise)
         req_q <= 1'b1;
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         req_vec_q <= VEC_RST;
         req_lvl_q <= SRC_LVL_OFF;
      end
      else if (raise)
      begin
         req_vec_q <= win.vec;
         req_lvl_q <= win.lvl;
      end
   end

   assign cpu_req = req_q;
   assign cpu_vec = req_vec_q;

   // ------------------------------------------------------------
   // Test register: capture select, level and held vector
   // ------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         capsel_q <= 1'b0;
      else if (wr_test)
         capsel_q <= wr.data[TST_CAPSEL_BIT];
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         new_lvl_q <= CPU_LVL_RST;
      else if (ack)
         new_lvl_q <= {1'b0, req_lvl_q};
      else if (wr_test)
         new_lvl_q <= wr.data[TST_LVL_LSB +: CPU_LVL_W];
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         held_vec_q <= VEC_RST;
      else if (ack)
         held_vec_q <= req_vec_q;
      else if (wr_test)
         held_vec_q <= wr.data[TST_VEC_LSB +: VEC_W];
   end

   assign cpu_new_level = new_lvl_q;

   // ------------------------------------------------------------
   // Event status and interrupt
   // ------------------------------------------------------------
   assign ev[EV_RAISE_BIT] = raise;
   assign ev[EV_ACK_BIT] = ack;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         stat_q <= EV_RST;
      else if (wr_stat)
         stat_q <= (stat_q & ~wr.data[EV_W-1:0]) | ev;
      else
         stat_q <= stat_q | ev;
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         mask_q <= EV_RST;
      else if (wr_mask)
         mask_q <= wr.data[EV_W-1:0];
   end

   assign irq = |(stat_q & mask_q);

   // ------------------------------------------------------------
   // Read data
   // ------------------------------------------------------------
   always_comb
   begin
      logic [REG_W-1:0] v;
      v = '0;
      rd_data = 32'h0000_0000;
      if (in_map(rd_addr))
      begin
         case (reg_index(rd_addr))
            reg_index(OFS_DBG_PRIO):
            begin
               v[DBG_LVL_LSB +: SRC_LVL_W] = dbg_lvl_q;
            end
            reg_index(OFS_TEST):
            begin
               v[TST_REQ_BIT] = req_q;
               v[TST_CAPSEL_BIT] = capsel_q;
               v[TST_LVL_LSB +: CPU_LVL_W] = new_lvl_q;
               v[TST_VEC_LSB +: VEC_W] = capsel_q ? win.vec : held_vec_q;
            end
            reg_index(OFS_IRQ_STAT):
            begin
               v[EV_W-1:0] = stat_q;
            end
            reg_index(OFS_IRQ_MASK):
            begin
               v[EV_W-1:0] = mask_q;
            end
            default:
            begin
               v = '0;
            end
         endcase
         rd_data = {16'h0000, v};
      end
   end

endmodule
`default_nettype wire

/* File: tb/ipt_checker.sv */
// Checker for the interrupt priority and test register block.
// Assumes it is bound to ipt_top and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module ipt_checker
   import ipt_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [NUM_SRC-1:0] src_pend,
   input wire logic [NUM_SRC*SRC_LVL_W-1:0] src_lvl,
   input wire logic [CPU_LVL_W-1:0] cpu_level,
   input wire logic cpu_ack,
   input wire logic cpu_req,
   input wire logic [VEC_W-1:0] cpu_vec,
   input wire logic [CPU_LVL_W-1:0] cpu_new_level
);
   logic [CPU_LVL_W-1:0] lvl_q;
   logic [CPU_LVL_W-1:0] cpl_q;
   logic [NUM_SRC-1:0] pend_q;
   logic tk;
   assign tk = hsel && hready && htrans == HTRANS_NONSEQ;
   default clocking dc @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         lvl_q <= '0;
         cpl_q <= '0;
         pend_q <= '0;
      end
      else
      begin
         lvl_q <= {1'b0, src_lvl[cpu_vec*SRC_LVL_W +: SRC_LVL_W]};
         cpl_q <= cpu_level;
         pend_q <= src_pend;
      end
   end
   property p_ack_clr;
      cpu_req && cpu_ack |=> !cpu_req;
   endproperty
   a_ack_clr: assert property (p_ack_clr) else $error("ack left request up");
   property p_req_hold;
      cpu_req && !cpu_ack |=> cpu_req && $stable(cpu_vec);
   endproperty
   a_req_hold: assert property (p_req_hold) else $error("request dropped");
   property p_new_lvl;
      cpu_req && cpu_ack && cpu_vec != DBG_VEC |=> cpu_new_level == lvl_q;
   endproperty
   a_new_lvl: assert property (p_new_lvl) else $error("new level wrong");
   property p_rank;
      $rose(cpu_req) && cpu_vec != DBG_VEC |->
         pend_q[cpu_vec] && {1'b0, src_lvl[cpu_vec*SRC_LVL_W +: SRC_LVL_W]} > cpl_q;
   endproperty
   a_rank: assert property (p_rank) else $error("request does not outrank");
   property p_vec_rng;
      cpu_req |-> cpu_vec <= 8'h76;
   endproperty
   a_vec_rng: assert property (p_vec_rng) else $error("vector out of range");
   property p_rd_wait;
      tk && !hwrite |=> !hreadyout ##1 hreadyout;
   endproperty
   a_rd_wait: assert property (p_rd_wait) else $error("read wait wrong");
   property p_wr_go;
      tk && hwrite |=> hreadyout;
   endproperty
   a_wr_go: assert property (p_wr_go) else $error("write stalled");
   property p_okay;
      hresp == HRESP_OKAY;
   endproperty
   a_okay: assert property (p_okay) else $error("response not okay");
endmodule
bind ipt_top ipt_checker i_ipt_checker (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready,
   .hreadyout, .hresp, .src_pend, .src_lvl, .cpu_level, .cpu_ack, .cpu_req, .cpu_vec,
   .cpu_new_level);
`default_nettype wire

/* File: tb/ipt_cpu_model.sv */
// CPU side model: acknowledges a standing request after a set delay.
// Assumes the same clock and reset as the controller.
`timescale 1ns/10ps
`default_nettype none
module ipt_cpu_model
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic cpu_req,
   input wire logic ack_en,
   input wire logic [3:0] ack_dly,
   output logic cpu_ack
);
   logic [3:0] cnt_q;
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         cnt_q <= '0;
         cpu_ack <= 1'b0;
      end
      else if (cpu_req && !cpu_ack && ack_en && cnt_q >= ack_dly)
      begin
         cnt_q <= '0;
         cpu_ack <= 1'b1;
      end
      else
      begin
         cnt_q <= (cpu_req && !cpu_ack) ? cnt_q + 4'h1 : 4'h0;
         cpu_ack <= 1'b0;
      end
   end
endmodule
`default_nettype wire

/* File: tb/interrupt_priority_test_regs_test.sv */
// Testbench for the interrupt priority and test register block.
// Assumes ipt_top on a 40 MHz clock and the CPU model answering requests.
`timescale 1ns/10ps
`default_nettype none
module interrupt_priority_test_regs_test
   import ipt_pkg::*;
;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = '0;
   logic [1:0] htrans = '0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = '0;
   logic [31:0] hrdata;
   logic hready, hreadyout, hresp, cpu_ack, cpu_req, irq;
   logic [NUM_SRC-1:0] src_pend = '0;
   logic [NUM_SRC*SRC_LVL_W-1:0] src_lvl = '0;
   logic [CPU_LVL_W-1:0] cpu_level = '0;
   logic [VEC_W-1:0] cpu_vec;
   logic [CPU_LVL_W-1:0] cpu_new_level;
   logic ack_en = 1'b0;
   logic [31:0] rdat;
   int fails = 0;
   int checked = 0;
   assign hready = hreadyout;
   always #12.5 hclk = ~hclk;
   ipt_top i_ipt_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .src_pend(src_pend),
      .src_lvl(src_lvl), .cpu_level(cpu_level), .cpu_ack(cpu_ack), .cpu_req(cpu_req),
      .cpu_vec(cpu_vec), .cpu_new_level(cpu_new_level), .irq(irq));
   ipt_cpu_model i_ipt_cpu_model (.hclk(hclk), .hresetn(hresetn), .cpu_req(cpu_req),
      .ack_en(ack_en), .ack_dly(4'h1), .cpu_ack(cpu_ack));
   task automatic final_report;
      if (fails == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e)
      begin
         fails++;
         $display("Error at %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic wait_rdy;
      int n;
      n = 0;
      @(negedge hclk);
      while (hreadyout !== 1'b1 && n < 20)
      begin
         n++;
         @(negedge hclk);
      end
      if (hreadyout !== 1'b1)
      begin
         fails++;
         final_report();
      end
      rdat = hrdata;
      @(posedge hclk);
   endtask
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= HTRANS_NONSEQ;
      haddr <= a;
      hwrite <= w;
      wait_rdy();
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      wait_rdy();
   endtask
   task automatic rd(input logic [31:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0000_0000);
      chk(rdat, e);
   endtask
   task automatic wait_req(input logic e);
      int n;
      n = 0;
      @(negedge hclk);
      while (cpu_req !== e && n < 20)
      begin
         n++;
         @(negedge hclk);
      end
      chk(32'(cpu_req), 32'(e));
      if (cpu_req !== e)
         final_report();
      @(posedge hclk);
   endtask
   initial
   begin
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      rd(OFS_DBG_PRIO, 32'h0000_0040);
      rd(OFS_TEST, 32'h0000_0000);
      rd(OFS_IRQ_MASK, 32'h0000_0000);
      rd(MAP_SIZE, 32'h0000_0000);
      for (int i = 0; i < 8; i++)
      begin
         bus(1'b1, OFS_DBG_PRIO, 32'hFFFF_FF8F | (32'(i) << 4));
         rd(OFS_DBG_PRIO, 32'(i) << 4);
      end
      bus(1'b1, OFS_TEST, 32'h0000_0F76);
      rd(OFS_TEST, 32'h0000_0F76);
      src_lvl[5*3 +: 3] <= 3'h4;
      src_lvl[118*3 +: 3] <= 3'h4;
      src_pend[5] <= 1'b1;
      src_pend[118] <= 1'b1;
      wait_req(1'b1);
      chk(32'(cpu_vec), 32'h0000_0005);
      rd(OFS_TEST, 32'h0000_8F76);
      bus(1'b1, OFS_TEST, 32'h0000_2000);
      rd(OFS_TEST, 32'h0000_A005);
      rd(OFS_IRQ_STAT, 32'h0000_0001);
      bus(1'b1, OFS_IRQ_MASK, 32'h0000_0003);
      rd(OFS_IRQ_MASK, 32'h0000_0003);
      chk(32'(irq), 32'h0000_0001);
      bus(1'b1, OFS_IRQ_STAT, 32'h0000_0001);
      rd(OFS_IRQ_STAT, 32'h0000_0000);
      chk(32'(irq), 32'h0000_0000);
      cpu_level <= 4'h4;
      ack_en <= 1'b1;
      wait_req(1'b0);
      chk(32'(cpu_new_level), 32'h0000_0004);
      rd(OFS_TEST, 32'h0000_2405);
      rd(OFS_IRQ_STAT, 32'h0000_0002);
      chk(32'(irq), 32'h0000_0001);
      src_pend[5] <= 1'b0;
      rd(OFS_TEST, 32'h0000_2476);
      bus(1'b1, OFS_TEST, 32'h0000_0000);
      ack_en <= 1'b0;
      src_lvl[118*3 +: 3] <= 3'h7;
      wait_req(1'b1);
      chk(32'(cpu_vec), 32'h0000_0076);
      rd(OFS_TEST, 32'h0000_8000);
      cpu_level <= 4'h7;
      ack_en <= 1'b1;
      wait_req(1'b0);
      rd(OFS_TEST, 32'h0000_0776);
      src_pend[118] <= 1'b0;
      cpu_level <= 4'h0;
      bus(1'b1, OFS_DBG_PRIO, 32'h0000_0000);
      src_pend[95] <= 1'b1;
      rd(OFS_TEST, 32'h0000_0776);
      ack_en <= 1'b0;
      bus(1'b1, OFS_DBG_PRIO, 32'h0000_0030);
      wait_req(1'b1);
      chk(32'(cpu_vec), 32'(DBG_VEC));
      ack_en <= 1'b1;
      wait_req(1'b0);
      chk(32'(cpu_new_level), 32'h0000_0003);
      wait_req(1'b1);
      src_pend[95] <= 1'b0;
      wait_req(1'b0);
      final_report();
   end
endmodule
`default_nettype wire
